// file: src/timer_two_pkg.sv
// Package holding constants and carrier types of the dual mode reload timer
// Notes on behaviour
// RULE_01 - Low byte overflow flag set by hardware on every low byte rollover, any mode.
// RULE_02 - Low byte overflow raises interrupt only when its enable and timer interrupts are on.
// RULE_03 - Split select: clear gives one 16-bit counter, set gives two 8-bit counters.
// RULE_04 - Run bit gates whole counter in 16-bit mode, only high byte in split mode.
// RULE_05 - External select picks system clock over 12 or synchronised oscillator over 8.
// RULE_06 - Eight bit readable and writable low reload register.
// RULE_07 - Separate eight bit high reload register.
// RULE_08 - Control register is bit addressable, resets to zero, own address.
// RULE_09 - High byte overflow flag set on high byte rollover from FF to 00.
// RULE_10 - Software clears both overflow flags; hardware never clears them.
// RULE_11 - 16-bit mode reloads both bytes on full rollover; split mode reloads per byte.
// RULE_12 - Unused control bit one reads zero and ignores writes.
package timer_two_pkg;

  localparam logic [7:0] ADDR_CONTROL     = 8'hC8;
  localparam logic [7:0] ADDR_RELOAD_LOW  = 8'hCA;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HIGH  = 8'hCD;

  localparam int BIT_HIGH_FLAG  = 7;
  localparam int BIT_LOW_FLAG   = 6;
  localparam int BIT_LOW_IRQEN  = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT      = 3;
  localparam int BIT_RUN        = 2;
  localparam int BIT_UNUSED     = 1;
  localparam int BIT_EXT_CLK    = 0;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] RELOAD_RESET  = 8'h00;
  localparam logic [7:0] WRITABLE_MASK = 8'hFD;

  localparam int          SYSTEM_CLOCK_DIV     = 12;
  localparam int          EXT_DIV        = 8;
  localparam logic [3:0]  PRESCALE_LAST  = 4'(SYSTEM_CLOCK_DIV - 1);
  localparam logic [2:0]  EXT_LAST       = 3'(EXT_DIV - 1);
  localparam logic [7:0]  BYTE_MAX       = 8'hFF;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       bit_wr;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic       tick_low;
    logic       tick_high;
  } tick_pair_t;

endpackage : timer_two_pkg

// file: src/tick_select.sv
// Clock source selection producing count ticks for each counter byte
`timescale 1ns/1ps
module tick_select
  import timer_two_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     nrst,
  input  wire logic                     ext_osc,
  input  wire logic                     external_clock_select,
  input  wire logic                     high_byte_system_clock_force,
  input  wire logic                     low_byte_system_clock_force,
  output timer_two_pkg::tick_pair_t     ticks
);

  logic [3:0] prescale_reg;
  logic [2:0] ext_count_reg;
  logic       sync1_reg;
  logic       sync2_reg;
  logic       sync3_reg;
  logic       div12_tick;
  logic       ext_tick;
  logic       sel_tick;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      prescale_reg <= 4'h0;
    else if (prescale_reg == PRESCALE_LAST)
      prescale_reg <= 4'h0;
    else
      prescale_reg <= prescale_reg + 4'h1;
  end

  // Two flops settle the oscillator; the third only feeds the edge detector
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= ext_osc;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      ext_count_reg <= 3'h0;
    else if (sync2_reg && !sync3_reg)
      ext_count_reg <= (ext_count_reg == EXT_LAST) ? 3'h0 : ext_count_reg + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign div12_tick = (prescale_reg == PRESCALE_LAST);
  assign ext_tick   = sync2_reg && !sync3_reg && (ext_count_reg == EXT_LAST);
  // RULE_05 source select
  assign sel_tick   = external_clock_select ? ext_tick : div12_tick;

  always_comb
  begin
    ticks.tick_high = high_byte_system_clock_force ? 1'b1 : sel_tick;
    ticks.tick_low  = low_byte_system_clock_force ? 1'b1 : sel_tick;
  end

endmodule : tick_select

// file: src/dual_mode_reload_timer_control.sv
// Control, reload and counter logic of the dual mode reload timer
`timescale 1ns/1ps
module dual_mode_reload_timer_control
(
  input  wire logic                     clk_sys,
  input  wire logic                     nrst,
  input  timer_two_pkg::sfr_req_t       sfr_req,
  input  wire logic                     ext_osc,
  input  wire logic                     timer_irq_enable,
  input  wire logic                     high_byte_system_clock_force,
  input  wire logic                     low_byte_system_clock_force,
  output logic [7:0]                    sfr_rdata,
  output logic                          timer_irq,
  output logic                          capture_enable
);
  import timer_two_pkg::*;

  logic [7:0]  control_reg;
  logic [7:0]  reload_low_reg;
  logic [7:0]  reload_high_reg;
  logic [7:0]  count_low_reg;
  logic [7:0]  count_high_reg;
  logic [7:0]  control_next;
  logic [7:0]  rdata_next;
  tick_pair_t  ticks;
  logic        split;
  logic        run;
  logic        inc_low;
  logic        inc_high;
  logic        low_roll;
  logic        high_roll;
  logic        wr_ctrl;
  logic        bitwr_ctrl;
  logic        byte_wr;
  logic        wr_count_low;
  logic        wr_count_high;
  logic        wr_reload_low;
  logic        wr_reload_high;
  logic        full_roll;
  logic        low_reload_now;
  logic        set_high_flag;
  logic        set_low_flag;
  logic        inc_low_split;
  logic        inc_high_split;
  logic        inc_low_full;
  logic        inc_high_full;

  tick_select u_tick_select
  (
    .clk_sys                (clk_sys),
    .nrst                   (nrst),
    .ext_osc                (ext_osc),
    .external_clock_select  (control_reg[BIT_EXT_CLK]),
    .high_byte_system_clock_force (high_byte_system_clock_force),
    .low_byte_system_clock_force  (low_byte_system_clock_force),
    .ticks                  (ticks)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign split = control_reg[BIT_SPLIT];
  assign run   = control_reg[BIT_RUN];

  // RULE_04 run gating
  assign inc_low_split  = ticks.tick_low;
  assign inc_high_split = run && ticks.tick_high;
  assign inc_low_full   = run && ticks.tick_high;
  assign inc_high_full  = inc_low_full && (count_low_reg == BYTE_MAX);

  always_comb
  begin
    // RULE_03 mode select
    if (split)
    begin
      inc_low  = inc_low_split;
      inc_high = inc_high_split;
    end
    else
    begin
      inc_low  = inc_low_full;
      inc_high = inc_high_full;
    end
  end

  // Rollover strobes of each byte
  assign low_roll  = inc_low && (count_low_reg == BYTE_MAX);
  assign high_roll = inc_high && (count_high_reg == BYTE_MAX);

  // Flag set strobes; a rollover beats a clearing write in the same cycle
  assign set_high_flag  = high_roll;
  assign set_low_flag   = low_roll;

  // In 16-bit mode the low byte reloads only with the full counter
  assign full_roll      = !split && inc_low && ({count_high_reg, count_low_reg} == {BYTE_MAX, BYTE_MAX});
  assign low_reload_now = split ? low_roll : full_roll;

  ////////////////////////////////////////////////////////////////////////////
  // RULE_11 low byte reload
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      count_low_reg <= 8'h00;
    else if (wr_count_low)
      count_low_reg <= sfr_req.wdata;
    else if (low_reload_now)
      count_low_reg <= reload_low_reg;
    else if (inc_low)
      count_low_reg <= count_low_reg + 8'h01;
  end

  // RULE_11 high byte reload
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      count_high_reg <= 8'h00;
    else if (wr_count_high)
      count_high_reg <= sfr_req.wdata;
    else if (high_roll)
      count_high_reg <= reload_high_reg;
    else if (inc_high)
      count_high_reg <= count_high_reg + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit writes reach the control register only; byte writes reach any register
  assign byte_wr        = sfr_req.wr && !sfr_req.bit_wr;
  assign wr_count_low   = byte_wr && (sfr_req.addr == ADDR_COUNT_LOW);
  assign wr_count_high  = byte_wr && (sfr_req.addr == ADDR_COUNT_HIGH);
  assign wr_reload_low  = byte_wr && (sfr_req.addr == ADDR_RELOAD_LOW);
  assign wr_reload_high = byte_wr && (sfr_req.addr == ADDR_RELOAD_HIGH);
  assign wr_ctrl        = byte_wr && (sfr_req.addr == ADDR_CONTROL);
  assign bitwr_ctrl     = sfr_req.wr && sfr_req.bit_wr && (sfr_req.addr == ADDR_CONTROL);

  always_comb
  begin
    control_next = control_reg;
    // RULE_08 byte and bit writes
    if (wr_ctrl)
      control_next = sfr_req.wdata;
    else if (bitwr_ctrl)
      control_next[sfr_req.bit_sel] = sfr_req.wdata[0];
    // RULE_12 unused bit
    control_next = control_next & WRITABLE_MASK;
    // RULE_10 flags only cleared by software; set wins over clear
    // RULE_09 high flag set
    if (set_high_flag)
      control_next[BIT_HIGH_FLAG] = 1'b1;
    // RULE_01 low flag set
    if (set_low_flag)
      control_next[BIT_LOW_FLAG] = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      control_reg <= CONTROL_RESET;
    else
      control_reg <= control_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // RULE_06 low reload
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      reload_low_reg <= RELOAD_RESET;
    else if (wr_reload_low)
      reload_low_reg <= sfr_req.wdata;
  end

  // RULE_07 high reload
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      reload_high_reg <= RELOAD_RESET;
    else if (wr_reload_high)
      reload_high_reg <= sfr_req.wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    // Unmapped addresses read as zero
    case (sfr_req.addr)
      ADDR_CONTROL:     rdata_next = control_reg;
      ADDR_RELOAD_LOW:  rdata_next = reload_low_reg;
      ADDR_RELOAD_HIGH: rdata_next = reload_high_reg;
      ADDR_COUNT_LOW:   rdata_next = count_low_reg;
      ADDR_COUNT_HIGH:  rdata_next = count_high_reg;
      default:          rdata_next = 8'h00;
    endcase
  end

  // Read data registered so the output comes from a flop; one cycle latency
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      sfr_rdata <= 8'h00;
    else if (sfr_req.rd)
      sfr_rdata <= rdata_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // RULE_02 interrupt request level
  // Built from the next control value so the request rises with its flag
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      timer_irq <= 1'b0;
    else
      timer_irq <= timer_irq_enable && (control_next[BIT_HIGH_FLAG]
                   || (control_next[BIT_LOW_IRQEN] && control_next[BIT_LOW_FLAG]));
  end

  // Mirrored out only; the capture path itself sits outside this block
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      capture_enable <= 1'b0;
    else
      capture_enable <= control_next[BIT_CAPTURE_EN];
  end

endmodule : dual_mode_reload_timer_control

// file: sim/timer_two_chk.sv
// Checker for the dual mode reload timer ports
`timescale 1ns/1ps
module timer_two_chk
  import timer_two_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               nrst,
  input timer_two_pkg::sfr_req_t sfr_req,
  input wire logic               ext_osc,
  input wire logic               timer_irq_enable,
  input wire logic               high_byte_system_clock_force,
  input wire logic               low_byte_system_clock_force,
  input wire logic [7:0]         sfr_rdata,
  input wire logic               timer_irq,
  input wire logic               capture_enable
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  wire rd_c = sfr_req.rd && sfr_req.addr == ADDR_CONTROL;
  wire wr_c = sfr_req.wr && sfr_req.addr == ADDR_CONTROL;
  ////////////////////////////////////////////////////////////
  property p_echo(a);
    sfr_req.wr && !sfr_req.bit_wr && sfr_req.addr == a ##1 sfr_req.rd && !sfr_req.wr && sfr_req.addr == a
      |=> sfr_rdata == $past(sfr_req.wdata, 2);
  endproperty
  a_low_reload_echo: assert property (p_echo(ADDR_RELOAD_LOW))
    else $error("low reload readback wrong");
  a_high_reload_echo: assert property (p_echo(ADDR_RELOAD_HIGH))
    else $error("high reload readback wrong");
  a_ctrl_echo: assert property (wr_c && !sfr_req.bit_wr ##1 rd_c && !sfr_req.wr
    |=> sfr_rdata[5:0] == ($past(sfr_req.wdata[5:0], 2) & 6'h3D)) else $error("control readback wrong");
  a_unused_zero: assert property (rd_c |=> !sfr_rdata[1])
    else $error("unused control bit read as one");
  a_unmapped_zero: assert property (sfr_req.rd && !(sfr_req.addr inside {8'hC8, [8'hCA:8'hCD]})
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  a_flags_sticky: assert property (rd_c && !sfr_req.wr ##1 rd_c && !sfr_req.wr
    |=> ($past(sfr_rdata[7:6]) & ~sfr_rdata[7:6]) == 2'b00) else $error("flag cleared by hardware");
  a_irq_gated: assert property (!timer_irq_enable [*2] |-> !timer_irq)
    else $error("interrupt while disabled");
  // Capture copy changes on the edge that takes the write, with no extra register stage
  a_cap_cause: assert property ($changed(capture_enable) |-> $past(wr_c) || $past(wr_c, 2))
    else $error("capture enable changed without write");
  a_rdata_hold: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
    else $error("read data moved without read");
  c_irq: cover property (timer_irq);
  c_high_flag: cover property (rd_c ##1 sfr_rdata[7]);
  c_capture: cover property (capture_enable);
endmodule : timer_two_chk
////////////////////////////////////////////////////////////
bind dual_mode_reload_timer_control timer_two_chk i_chk (.clk_sys(clk_sys), .nrst(nrst), .sfr_req(sfr_req),
  .ext_osc(ext_osc), .timer_irq_enable(timer_irq_enable), .high_byte_system_clock_force(high_byte_system_clock_force),
  .low_byte_system_clock_force(low_byte_system_clock_force), .sfr_rdata(sfr_rdata), .timer_irq(timer_irq),
  .capture_enable(capture_enable));

// file: sim/tb.sv
// Self-checking bench of the dual mode reload timer
`timescale 1ns/1ps
module tb;
  import timer_two_pkg::*;
  logic        clk_sys, nrst, ext_osc, irq_en, hi_frc, lo_frc, irq, cap;
  logic        rd_seen = 1'b0;
  sfr_req_t    req;
  logic [7:0]  rdata;
  logic [7:0]  exp_q[$];
  logic [15:0] rl;
  int          error_cnt, checks_done;
  dual_mode_reload_timer_control i_dut (.clk_sys(clk_sys), .nrst(nrst), .sfr_req(req), .ext_osc(ext_osc),
    .timer_irq_enable(irq_en), .high_byte_system_clock_force(hi_frc), .low_byte_system_clock_force(lo_frc),
    .sfr_rdata(rdata), .timer_irq(irq), .capture_enable(cap));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic put(input logic w, r, b, input logic [2:0] s, input logic [7:0] a, d);
    @(posedge clk_sys);
    #1;
    req = '{wr: w, rd: r, bit_wr: b, addr: a, bit_sel: s, wdata: d};
  endtask : put
  task automatic wr(input logic [7:0] a, d);
    put(1, 0, 0, 0, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    put(0, 1, 0, 0, a, 8'h00);
  endtask : rd
  task automatic idle(input int n);
    put(0, 0, 0, 0, 8'h00, 8'h00);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle
  task automatic finish_test;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////
  // Read data is settled by the falling edge after the taking edge
  always @(posedge clk_sys) rd_seen <= req.rd;
  always @(negedge clk_sys) if (rd_seen) chk(rdata, exp_q.pop_front());
  initial
  begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial
  begin
    #20000;
    error_cnt++;
    finish_test();
  end
  initial
  begin
    {nrst, ext_osc, irq_en, hi_frc, lo_frc} = '0;
    req = '0;
    rl = 16'($urandom(32'h4be0));
    repeat (4) @(posedge clk_sys);
    #1 nrst = 1;
    rd(ADDR_CONTROL, CONTROL_RESET);
    rd(ADDR_RELOAD_LOW, RELOAD_RESET);
    rd(8'hC9, 8'h00);
    wr(ADDR_CONTROL, 8'h3E);
    rd(ADDR_CONTROL, 8'h3C);
    wr(ADDR_CONTROL, 8'h00);
    put(1, 0, 1, 3'd4, ADDR_CONTROL, 8'h01);
    rd(ADDR_CONTROL, 8'h10);
    idle(2);
    chk(8'(cap), 8'h01);
    rl = 16'($urandom());
    wr(ADDR_RELOAD_LOW, rl[7:0]);
    rd(ADDR_RELOAD_LOW, rl[7:0]);
    wr(ADDR_RELOAD_HIGH, rl[15:8]);
    rd(ADDR_RELOAD_HIGH, rl[15:8]);
    wr(ADDR_COUNT_LOW, 8'hFF);
    wr(ADDR_COUNT_HIGH, 8'hFF);
    wr(ADDR_CONTROL, 8'h05);
    rd(ADDR_CONTROL, 8'h05);
    // Exactly eight oscillator rises give one count tick
    repeat (16)
    begin
      ext_osc = ~ext_osc;
      idle(1);
    end
    idle(20);
    rd(ADDR_COUNT_LOW, rl[7:0]);
    rd(ADDR_COUNT_HIGH, rl[15:8]);
    rd(ADDR_CONTROL, 8'hC5);
    rd(ADDR_CONTROL, 8'hC5);
    irq_en = 1;
    idle(2);
    chk(8'(irq), 8'h01);
    wr(ADDR_CONTROL, 8'h05);
    idle(2);
    chk(8'(irq), 8'h00);
    wr(ADDR_RELOAD_LOW, 8'h00);
    wr(ADDR_COUNT_LOW, 8'hFE);
    wr(ADDR_CONTROL, 8'h08);
    {hi_frc, lo_frc} = 2'b11;
    idle(6);
    rd(ADDR_CONTROL, 8'h48);
    rd(ADDR_COUNT_HIGH, rl[15:8]);
    idle(2);
    chk(8'(irq), 8'h00);
    wr(ADDR_CONTROL, 8'h68);
    idle(2);
    chk(8'(irq), 8'h01);
    wr(ADDR_CONTROL, 8'h00);
    idle(2);
    chk(8'(irq), 8'h00);
    // Any run of whole divider periods holds exactly one tick per period
    {hi_frc, lo_frc} = 2'b00;
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_CONTROL, 8'h04);
    idle(3 * SYSTEM_CLOCK_DIV - 2);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_COUNT_LOW, 8'h03);
    rd(ADDR_COUNT_HIGH, 8'h00);
    idle(SYSTEM_CLOCK_DIV);
    rd(ADDR_COUNT_LOW, 8'h03);
    finish_test();
  end
endmodule : tb
